// *** sspseq_top.sv ***
`timescale 1ns/1ps
// Notes on behaviour
// [R1] Start-up ramps reference from zero to the coded value over 2048 clocks.
// [R2] Upper and lower switches start switching as soon as the ramp begins.
// [R3] Power-good is held low during the ramp, enabled only after it.
// [R4] Once enabled, power-good pulls low when output leaves the 12 percent window.
// [R5] Output below 60 percent for over one clock turns switches off, raises fault.
// [R6] Under-voltage shutdown is latched until the power is cycled; the code releases it only on RST.
// [R7] Over-voltage holds low sides on, high sides off, raises fault permanently.
// [R8] Only a control supply cycle releases the over-voltage latch; the code releases it only on RST.
// [R9] Ramp uses rising reference for under-voltage, final reference for over-voltage; the code compares with OVERVOLTAGE_THRESHOLD_LEVEL.
// [R10] Under-voltage check is off until the ramp reference reaches 0.6 V.
// [R11] The ramp waits until both supplies are above their turn-on thresholds.
// [R12] Loss of either supply during operation shuts the device down.
// [R13] Inhibit pin held low turns off all switches and protections until released; the code ignores it in either latch.
// [R14] Under-voltage in constant-current operation also stops until the supply cycles; the code releases it only on RST.
// [R15] Inhibit holds the ramp counter at zero; release starts a fresh ramp.
module sspseq_top #(
    parameter int REF_W  = sspseq_pkg::REF_W,
    parameter int RAMP_W = sspseq_pkg::RAMP_W
) (
    input  wire logic              CLK,
    input  wire logic              RST,
    input  wire logic [REF_W-1:0]  VOLTAGE_CODE_REF,
    input  wire logic [REF_W-1:0]  SENSED_OUTPUT_INPUT,
    input  wire logic [REF_W-1:0]  OVERVOLTAGE_THRESHOLD_LEVEL,
    input  wire logic [REF_W-1:0]  UV_ENABLE_LEVEL,
    input  wire logic              CONTROL_SUPPLY_OK,
    input  wire logic              DRIVER_SUPPLY_OK,
    input  wire logic              INHIBIT_N,
    output logic [REF_W-1:0]       RAMP_REF,
    output logic                   SWITCHING_EN,
    output logic                   LOW_SIDE_FORCE_ON,
    output logic                   HIGH_SIDE_FORCE_OFF,
    output logic                   OUTPUT_IN_WINDOW_FLAG_OUT,
    output logic                   OUTPUT_IN_WINDOW_FLAG_OE,
    output logic                   OSC_INHIBIT_FAULT_PIN_OUT,
    output logic                   OSC_INHIBIT_FAULT_PIN_OE,
    output logic                   RAMP_DONE
);

    // ------------------------------------------------------------
    // Input synchronisers for pins from outside the clock domain
    // ------------------------------------------------------------
    logic [2:0] sync1_reg;
    logic [2:0] sync2_reg;
    logic       csup_ok;
    logic       dsup_ok;
    logic       inhibit;

    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST)
        begin
            sync1_reg <= 3'h0;
            sync2_reg <= 3'h0;
        end
        else
        begin
            sync1_reg <= {~INHIBIT_N, DRIVER_SUPPLY_OK, CONTROL_SUPPLY_OK};
            sync2_reg <= sync1_reg;
        end
    end

    assign csup_ok = sync2_reg[0];
    assign dsup_ok = sync2_reg[1];
    assign inhibit = sync2_reg[2];

    logic [REF_W-1:0] sensed_output_input_s1_reg;
    logic [REF_W-1:0] sensed_output_input_reg;

    // The sensed level is a converter output sampled here; it is treated as a stable word.
    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST)
        begin
            sensed_output_input_s1_reg <= '0;
            sensed_output_input_reg    <= '0;
        end
        else
        begin
            sensed_output_input_s1_reg <= SENSED_OUTPUT_INPUT;
            sensed_output_input_reg    <= sensed_output_input_s1_reg;
        end
    end

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    sspseq_pkg::sspseq_state_t state_reg;
    sspseq_pkg::sspseq_state_t state_next;
    logic [RAMP_W-1:0]         ramp_cnt_reg;
    logic                      ramp_last;
    logic                      supplies_ok;
    logic                      uv_trip;
    logic                      ov_trip;

    localparam logic [RAMP_W-1:0] RAMP_MAX =
        RAMP_W'(sspseq_pkg::RAMP_CLOCKS - 1);

    assign supplies_ok = csup_ok & dsup_ok;
    assign ramp_last   = (ramp_cnt_reg == RAMP_MAX);

    always_comb
    begin
        state_next = state_reg;
        unique case (state_reg)
            sspseq_pkg::SSPSEQ_OFF:
                // [R11] Supplies gate start.
                if (supplies_ok && !inhibit)
                    state_next = sspseq_pkg::SSPSEQ_RAMP;
            sspseq_pkg::SSPSEQ_RAMP, sspseq_pkg::SSPSEQ_RUN:
                // [R12] [R13] Supply loss or inhibit overrides protections.
                if (inhibit || !supplies_ok)
                    state_next = sspseq_pkg::SSPSEQ_OFF;
                else if (ov_trip)
                    state_next = sspseq_pkg::SSPSEQ_OV_LATCH;
                else if (uv_trip)
                    state_next = sspseq_pkg::SSPSEQ_UV_LATCH;
                else if (state_reg == sspseq_pkg::SSPSEQ_RAMP && ramp_last)
                    state_next = sspseq_pkg::SSPSEQ_RUN;
            // [R6] [R8] [R14] Latches released only by power reset.
            sspseq_pkg::SSPSEQ_UV_LATCH: state_next = sspseq_pkg::SSPSEQ_UV_LATCH;
            sspseq_pkg::SSPSEQ_OV_LATCH: state_next = sspseq_pkg::SSPSEQ_OV_LATCH;
            default:                     state_next = sspseq_pkg::SSPSEQ_OFF;
        endcase
    end

    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST)
            state_reg <= sspseq_pkg::SSPSEQ_OFF;
        else
            state_reg <= state_next;
    end

    // [R1] [R15] Ramp counter.
    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST)
            ramp_cnt_reg <= '0;
        else if (state_reg != sspseq_pkg::SSPSEQ_RAMP || state_next != sspseq_pkg::SSPSEQ_RAMP)
            ramp_cnt_reg <= (state_reg == sspseq_pkg::SSPSEQ_RAMP
                             && state_next == sspseq_pkg::SSPSEQ_RUN) ? RAMP_MAX : '0;
        else
            ramp_cnt_reg <= ramp_cnt_reg + RAMP_W'(1);
    end

    // ------------------------------------------------------------
    // References and comparators
    // ------------------------------------------------------------
    logic [REF_W-1:0]       ramp_ref;
    logic [REF_W+RAMP_W:0]  ramp_prod;
    logic [REF_W+7:0]       sensed_output_input_pct;
    logic [REF_W+7:0]       uv_limit;
    logic [REF_W+7:0]       win_lo;
    logic [REF_W+7:0]       win_hi;
    logic                   uv_below;
    logic                   uv_armed;
    logic                   uv_below_d_reg;
    logic                   in_window;

    // [R1] Reference scales with the ramp count, final value in run.
    assign ramp_prod = (REF_W+RAMP_W+1)'(VOLTAGE_CODE_REF) * (REF_W+RAMP_W+1)'(ramp_cnt_reg);
    always_comb
    begin
        if (state_reg == sspseq_pkg::SSPSEQ_RUN)
            ramp_ref = VOLTAGE_CODE_REF;
        else if (state_reg == sspseq_pkg::SSPSEQ_RAMP)
            ramp_ref = REF_W'(ramp_prod >> RAMP_W);
        else
            ramp_ref = '0;
    end

    // [R9] Under-voltage follows the ramping reference.
    assign sensed_output_input_pct = (REF_W+8)'(sensed_output_input_reg) * (REF_W+8)'(sspseq_pkg::PCT_FULL);
    assign uv_limit = (REF_W+8)'(ramp_ref) * (REF_W+8)'(sspseq_pkg::UNDER_PCT);
    assign win_lo   = (REF_W+8)'(VOLTAGE_CODE_REF)
                    * (REF_W+8)'(sspseq_pkg::PCT_FULL - sspseq_pkg::WINDOW_PCT);
    assign win_hi   = (REF_W+8)'(VOLTAGE_CODE_REF)
                    * (REF_W+8)'(sspseq_pkg::PCT_FULL + sspseq_pkg::WINDOW_PCT);
    assign uv_below = sensed_output_input_pct < uv_limit;
    // [R10] Under-voltage armed once reference reaches UV_ENABLE_LEVEL.
    assign uv_armed = (ramp_ref >= UV_ENABLE_LEVEL);

    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST)
            uv_below_d_reg <= 1'b0;
        else
            uv_below_d_reg <= uv_below && uv_armed;
    end

    // [R5] Low for more than one clock trips.
    assign uv_trip  = uv_below && uv_armed && uv_below_d_reg;
    // [R9] Over-voltage uses fixed threshold, active through the ramp.
    assign ov_trip  = (sensed_output_input_reg >= OVERVOLTAGE_THRESHOLD_LEVEL);
    assign in_window = (sensed_output_input_pct >= win_lo) && (sensed_output_input_pct <= win_hi);

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST)
        begin
            RAMP_REF            <= '0;
            SWITCHING_EN        <= 1'b0;
            LOW_SIDE_FORCE_ON   <= 1'b0;
            HIGH_SIDE_FORCE_OFF <= 1'b1;
            OUTPUT_IN_WINDOW_FLAG_OE <= 1'b1;
            OSC_INHIBIT_FAULT_PIN_OE <= 1'b0;
            RAMP_DONE           <= 1'b0;
        end
        else
        begin
            RAMP_REF <= ramp_ref;
            // [R2] Switching during ramp and run only.
            SWITCHING_EN <= (state_reg == sspseq_pkg::SSPSEQ_RAMP)
                         || (state_reg == sspseq_pkg::SSPSEQ_RUN);
            // [R7] Crowbar holds low sides on.
            LOW_SIDE_FORCE_ON   <= (state_reg == sspseq_pkg::SSPSEQ_OV_LATCH);
            HIGH_SIDE_FORCE_OFF <= (state_reg != sspseq_pkg::SSPSEQ_RAMP)
                                && (state_reg != sspseq_pkg::SSPSEQ_RUN);
            // [R3] [R4] Power-good pulled low outside run or window.
            OUTPUT_IN_WINDOW_FLAG_OE <= !((state_reg == sspseq_pkg::SSPSEQ_RUN) && in_window);
            // [R5] [R7] Fault pin driven high in either latch.
            OSC_INHIBIT_FAULT_PIN_OE <= (state_reg == sspseq_pkg::SSPSEQ_UV_LATCH)
                                     || (state_reg == sspseq_pkg::SSPSEQ_OV_LATCH);
            RAMP_DONE <= (state_reg == sspseq_pkg::SSPSEQ_RUN);
        end
    end

    assign OUTPUT_IN_WINDOW_FLAG_OUT = 1'b0;
    assign OSC_INHIBIT_FAULT_PIN_OUT = 1'b1;

    // ------------------------------------------------------------
    // Assertion helpers
    // ------------------------------------------------------------
    // Counts ramp cycles apart from the ramp counter, so the length check
    // does not lean on the very logic that it guards.
    localparam logic [RAMP_W:0] AGE_LAST = (RAMP_W+1)'(sspseq_pkg::RAMP_CLOCKS - 1);
    logic [RAMP_W:0]            ramp_age_reg;

    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST)
            ramp_age_reg <= '0;
        else if (state_reg == sspseq_pkg::SSPSEQ_RAMP)
            ramp_age_reg <= ramp_age_reg + (RAMP_W+1)'(1);
        else
            ramp_age_reg <= '0;
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    sequence s_ramp_full;
        state_reg == sspseq_pkg::SSPSEQ_RAMP && state_next == sspseq_pkg::SSPSEQ_RUN;
    endsequence

    a_output_in_window_flag_low_ramp: assert property (@(posedge CLK) disable iff (RST) // [R3]
        state_reg == sspseq_pkg::SSPSEQ_RAMP |=> OUTPUT_IN_WINDOW_FLAG_OE)
        else $error("power-good released during ramp");
    a_ramp_done_len: assert property (@(posedge CLK) disable iff (RST) // [R1]
        s_ramp_full |-> ramp_age_reg == AGE_LAST)
        else $error("ramp ended early");
    a_uv_latched: assert property (@(posedge CLK) disable iff (RST) // [R6]
        state_reg == sspseq_pkg::SSPSEQ_UV_LATCH |=> state_reg == sspseq_pkg::SSPSEQ_UV_LATCH)
        else $error("under-voltage latch released");
    a_ov_crowbar: assert property (@(posedge CLK) disable iff (RST) // [R7]
        state_reg == sspseq_pkg::SSPSEQ_OV_LATCH |=> LOW_SIDE_FORCE_ON && HIGH_SIDE_FORCE_OFF
        && OSC_INHIBIT_FAULT_PIN_OE)
        else $error("crowbar not applied");
    a_ov_hold: assert property (@(posedge CLK) disable iff (RST) // [R8]
        state_reg == sspseq_pkg::SSPSEQ_OV_LATCH |=> $stable(state_reg))
        else $error("over-voltage latch left");
    a_uv_two_clk: assert property (@(posedge CLK) disable iff (RST) // [R5]
        uv_trip && !inhibit && supplies_ok && !ov_trip
        && state_reg == sspseq_pkg::SSPSEQ_RUN |=> ##1 !SWITCHING_EN && OSC_INHIBIT_FAULT_PIN_OE)
        else $error("under-voltage not handled");
    a_no_start_supply: assert property (@(posedge CLK) disable iff (RST) // [R11]
        state_reg == sspseq_pkg::SSPSEQ_OFF && !supplies_ok |=> state_reg == sspseq_pkg::SSPSEQ_OFF)
        else $error("ramp started without supplies");
    a_inhibit_off: assert property (@(posedge CLK) disable iff (RST) // [R13]
        inhibit && state_reg != sspseq_pkg::SSPSEQ_UV_LATCH
        && state_reg != sspseq_pkg::SSPSEQ_OV_LATCH |=> ##1 !SWITCHING_EN)
        else $error("switching while inhibited");
    a_uv_disarmed: assert property (@(posedge CLK) disable iff (RST) // [R10]
        state_reg != sspseq_pkg::SSPSEQ_UV_LATCH ##1 state_reg == sspseq_pkg::SSPSEQ_UV_LATCH
        |-> $past(ramp_ref) >= UV_ENABLE_LEVEL)
        else $error("under-voltage armed too early");
    a_off_ref_zero: assert property (@(posedge CLK) disable iff (RST) // [R13]
        state_reg == sspseq_pkg::SSPSEQ_OFF |=> RAMP_REF == '0)
        else $error("reference not zero while off");
    a_pg_window: assert property (@(posedge CLK) disable iff (RST) // [R4]
        state_reg == sspseq_pkg::SSPSEQ_RUN && !in_window |=> OUTPUT_IN_WINDOW_FLAG_OE)
        else $error("power-good released outside window");
    a_fault_latch_only: assert property (@(posedge CLK) disable iff (RST) // [R5]
        OSC_INHIBIT_FAULT_PIN_OE |-> $past(state_reg) == sspseq_pkg::SSPSEQ_UV_LATCH
        || $past(state_reg) == sspseq_pkg::SSPSEQ_OV_LATCH)
        else $error("fault pin driven without a latch");
    a_uv_latch_off: assert property (@(posedge CLK) disable iff (RST) // [R14]
        state_reg == sspseq_pkg::SSPSEQ_UV_LATCH |=> !SWITCHING_EN && HIGH_SIDE_FORCE_OFF
        && OSC_INHIBIT_FAULT_PIN_OE)
        else $error("switches not off in under-voltage latch");
    a_inh_cnt_zero: assert property (@(posedge CLK) disable iff (RST) // [R15]
        state_reg == sspseq_pkg::SSPSEQ_OFF |=> ramp_cnt_reg == '0)
        else $error("ramp counter not cleared");

endmodule // sspseq_top

// *** sspseq_pkg.sv ***
package sspseq_pkg;

    // ------------------------------------------------------------
    // Soft start
    // ------------------------------------------------------------
    localparam int unsigned RAMP_CLOCKS = 2048;
    localparam int          RAMP_W      = 11;
    localparam int          REF_W       = 12;

    // ------------------------------------------------------------
    // Monitor thresholds, in percent of the programmed reference
    // ------------------------------------------------------------
    localparam int unsigned WINDOW_PCT   = 12;
    localparam int unsigned UNDER_PCT    = 60;
    localparam int unsigned PCT_FULL     = 100;
    // Under-voltage enable level in mV; unused, the check compares with the UV_ENABLE_LEVEL input.
    localparam int unsigned UV_ENABLE_MV = 600;
    localparam int unsigned UV_FILTER    = 1;

    // ------------------------------------------------------------
    // Sequencer states
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        SSPSEQ_OFF     = 3'b000,
        SSPSEQ_RAMP    = 3'b001,
        SSPSEQ_RUN     = 3'b010,
        SSPSEQ_UV_LATCH = 3'b011,
        SSPSEQ_OV_LATCH = 3'b100
    } sspseq_state_t;

endpackage

// *** sspseq_far_side.sv ***
`timescale 1ns/1ps
// ------------------------------------------------------------
// Power stage and output sensing model
// ------------------------------------------------------------
module sspseq_far_side (
    input  wire logic        clk,
    input  wire logic        switching_en,
    input  wire logic        low_side_force_on,
    input  wire logic [11:0] ramp_ref,
    input  wire logic [11:0] ov_level,
    input  wire logic [1:0]  fault_mode,
    output logic      [11:0] sensed
);
    logic [15:0] scaled;

    initial sensed = 12'h000;
    always_comb scaled = {4'h0, ramp_ref} * 16'h0004 / 16'h0005;

    // The output follows the reference only while the stage switches; a stalled stage
    // discharges to zero, except in fault_mode 2, which holds ov_level until low_side_force_on is set.
    always @(posedge clk)
    begin
        if (low_side_force_on)
            sensed <= 12'h000;
        else if (fault_mode == 2'h2)
            sensed <= ov_level;
        else if (!switching_en)
            sensed <= 12'h000;
        else if (fault_mode == 2'h1)
            sensed <= ramp_ref >> 1;
        else if (fault_mode == 2'h3)
            sensed <= scaled[11:0];
        else
            sensed <= ramp_ref;
    end
endmodule // sspseq_far_side

// *** test_softstart_protection_seq.sv ***
`timescale 1ns/1ps
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin n_errors++; \
    $display("MISMATCH %s expected %0h seen %0h", nm, e, g); end end
module test_softstart_protection_seq;
    localparam logic [5:0] OFF_S = 6'b001100;
    localparam logic [5:0] RUN_S = 6'b100001;
    localparam logic [5:0] WIN_S = 6'b100101;
    localparam logic [5:0] UVL_S = 6'b001110;
    localparam logic [5:0] OVL_S = 6'b011110;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic [11:0] vcr = 12'h800;
    logic [11:0] ov_lvl = 12'hfff;
    logic [11:0] uv_lvl = 12'h400;
    logic        ctl_ok = 1'b0;
    logic        drv_ok = 1'b0;
    logic        inh_n = 1'b1;
    logic [1:0]  mode = 2'h0;
    logic [11:0] sensed;
    logic [11:0] rref;
    logic        sw_en, ls_on, hs_off, flag_oe, fault_oe, done;
    logic [5:0]  exp_q[$];
    logic [5:0]  exp_v;
    event        snap_ev;
    int          n_errors = 0;
    int          total_checks = 0;
    int          seed = 32'hb74c;
    int          n;
    int          arm;
    wire  [5:0]  obs = {sw_en, ls_on, hs_off, flag_oe, fault_oe, done};

    always #4 clk = ~clk;

    sspseq_top DUT (.CLK(clk), .RST(rst), .VOLTAGE_CODE_REF(vcr), .SENSED_OUTPUT_INPUT(sensed),
        .OVERVOLTAGE_THRESHOLD_LEVEL(ov_lvl), .UV_ENABLE_LEVEL(uv_lvl),
        .CONTROL_SUPPLY_OK(ctl_ok), .DRIVER_SUPPLY_OK(drv_ok), .INHIBIT_N(inh_n),
        .RAMP_REF(rref), .SWITCHING_EN(sw_en), .LOW_SIDE_FORCE_ON(ls_on),
        .HIGH_SIDE_FORCE_OFF(hs_off), .OUTPUT_IN_WINDOW_FLAG_OUT(),
        .OUTPUT_IN_WINDOW_FLAG_OE(flag_oe), .OSC_INHIBIT_FAULT_PIN_OUT(),
        .OSC_INHIBIT_FAULT_PIN_OE(fault_oe), .RAMP_DONE(done));

    sspseq_far_side far_side (.clk(clk), .switching_en(sw_en), .low_side_force_on(ls_on),
        .ramp_ref(rref), .ov_level(ov_lvl), .fault_mode(mode), .sensed(sensed));

    // ------------------------------------------------------------
    // Output watcher and helpers
    // ------------------------------------------------------------
    always @(snap_ev)
    begin
        exp_v = exp_q.pop_front();
        `CHK("outputs", exp_v, obs)
    end

    task note(input logic [5:0] e);
        exp_q.push_back(e);
        ->snap_ev;
    endtask

    task test_done;
        $display("checks %0d mismatches %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    task wait_until(input int sel, input int lim);
        n = 0;
        while (!((sel == 0 && sw_en === 1'b1) || (sel == 2 && fault_oe === 1'b1)
                 || (sel == 3 && sw_en === 1'b0)))
        begin
            @(negedge clk);
            n++;
            if (n > lim)
            begin
                n_errors++;
                $display("MISMATCH wait %0d expected event seen timeout", sel);
                test_done;
            end
        end
    endtask

    task power(input logic c, input logic d, input logic i, input logic [1:0] m);
        @(negedge clk);
        ctl_ok = c;
        drv_ok = d;
        inh_n = i;
        mode = m;
    endtask

    task do_reset;
        @(negedge clk);
        rst = 1'b1;
        vcr = 12'h800 + 12'($random(seed) & 32'h3ff);
        ov_lvl = vcr + (vcr >> 2);
        uv_lvl = vcr >> 1;
        power(1'b0, 1'b0, 1'b1, 2'h0);
        repeat (4) @(negedge clk);
        rst = 1'b0;
    endtask

    task ramp_full;
        logic [11:0] prev;
        int          bad;
        wait_until(0, 10);
        prev = 12'h000;
        bad = 0;
        n = 0;
        while (done !== 1'b1 && n < 2100)
        begin
            if (flag_oe !== 1'b1 || fault_oe !== 1'b0 || rref < prev)
                bad++;
            prev = rref;
            @(negedge clk);
            n++;
        end
        `CHK("ramp_len", 2048, n)
        `CHK("ramp_bad", 0, bad)
        `CHK("final_ref", vcr, rref)
        note(RUN_S);
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    initial
    begin
        do_reset;
        note(OFF_S);
        power(1'b1, 1'b0, 1'b1, 2'h0);
        repeat (20) @(negedge clk);
        note(OFF_S);
        power(1'b0, 1'b1, 1'b1, 2'h0);
        repeat (20) @(negedge clk);
        note(OFF_S);
        `CHK("gated_ref", 12'h000, rref)
        $display("test supply gating done");
        power(1'b1, 1'b1, 1'b1, 2'h0);
        ramp_full;
        power(1'b1, 1'b1, 1'b1, 2'h3);
        repeat (8) @(negedge clk);
        note(WIN_S);
        power(1'b1, 1'b1, 1'b1, 2'h0);
        repeat (8) @(negedge clk);
        note(RUN_S);
        power(1'b1, 1'b0, 1'b1, 2'h0);
        wait_until(3, 8);
        repeat (2) @(negedge clk);
        note(OFF_S);
        power(1'b1, 1'b1, 1'b1, 2'h0);
        repeat (300) @(negedge clk);
        power(1'b1, 1'b1, 1'b0, 2'h0);
        repeat (8) @(negedge clk);
        note(OFF_S);
        `CHK("inhibit_ref", 12'h000, rref)
        power(1'b1, 1'b1, 1'b1, 2'h0);
        ramp_full;
        $display("test start and inhibit done");
        power(1'b1, 1'b1, 1'b1, 2'h1);
        wait_until(2, 10);
        repeat (2) @(negedge clk);
        note(UVL_S);
        power(1'b0, 1'b0, 1'b0, 2'h0);
        repeat (8) @(negedge clk);
        power(1'b1, 1'b1, 1'b1, 2'h0);
        repeat (8) @(negedge clk);
        note(UVL_S);
        do_reset;
        power(1'b1, 1'b1, 1'b1, 2'h1);
        wait_until(0, 10);
        arm = 0;
        n = 0;
        while (fault_oe !== 1'b1 && arm < 16 && n < 2100)
        begin
            if (rref >= uv_lvl)
                arm++;
            @(negedge clk);
            n++;
        end
        `CHK("uv_armed", 1'b1, arm > 0)
        `CHK("uv_fired", 1'b1, fault_oe)
        $display("test under-voltage done");
        do_reset;
        power(1'b1, 1'b1, 1'b1, 2'h0);
        wait_until(0, 10);
        repeat (100) @(negedge clk);
        power(1'b1, 1'b1, 1'b1, 2'h2);
        wait_until(2, 10);
        repeat (2) @(negedge clk);
        note(OVL_S);
        power(1'b0, 1'b0, 1'b0, 2'h0);
        repeat (8) @(negedge clk);
        power(1'b1, 1'b1, 1'b1, 2'h0);
        repeat (8) @(negedge clk);
        note(OVL_S);
        $display("test over-voltage done");
        test_done;
    end
endmodule // test_softstart_protection_seq
